// >>> verilog/ic_pkg.sv
/*
  Shared constants and types for the immediate command interpreter:
  register map, field positions, command and signal codes, routing types.
  Assumes a 32-bit APB master and four axis command slots.
*/
package ic_pkg;

  // ==========
  // Register map.
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT   = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_PARAM_IDX  = 8'h10;
  localparam logic [7:0] ADDR_PARAM_DATA = 8'h14;
  localparam logic [2:0] CMD_REGION      = 3'h1;

  // ==========
  // Field positions.
  localparam int CTRL_JOG_LSB     = 0;
  localparam int CTRL_HOME_LSB    = 4;
  localparam int CTRL_HOLD_LSB    = 8;
  localparam int CTRL_ABORT_LSB   = 12;
  localparam int CTRL_DIGITAL_LSB = 16;
  localparam int CTRL_WIDTH       = 20;
  localparam int STAT_NEWCFG_BIT  = 0;
  localparam int STAT_ACTIVE_LSB  = 4;
  localparam int STAT_ROUTE_LSB   = 16;
  localparam int INT_DONE         = 0;
  localparam int INT_CONFLICT     = 1;
  localparam int INT_BADCMD       = 2;
  localparam int INT_PARAM        = 3;
  localparam int INT_WIDTH        = 4;
  localparam int NUM_AXES         = 4;

  // ==========
  // Command, connector and signal codes.
  localparam logic [7:0] CODE_VEL_MOVE   = 8'h20;
  localparam logic [7:0] CODE_MOVE       = 8'h21;
  localparam logic [7:0] CODE_FORCE_VEL  = 8'h22;
  localparam logic [7:0] CODE_FORCE_ANA  = 8'h23;
  localparam logic [7:0] CODE_POS_INC    = 8'h24;
  localparam logic [7:0] CODE_ROUTE      = 8'h47;
  localparam logic [7:0] CODE_CLR_CFG    = 8'h48;
  localparam logic [7:0] CODE_LOAD_PARAM = 8'h49;
  localparam logic [7:0] CONN_FIRST      = 8'h01;
  localparam logic [7:0] CONN_LAST       = 8'h04;
  localparam logic [15:0] SIG_CODE_FORCED = 16'h0000;
  localparam logic [15:0] SIG_CODE_TQ1    = 16'h000a;
  localparam logic [15:0] SIG_CODE_VEL1   = 16'h000f;
  localparam logic [15:0] SIG_CODE_TQ2    = 16'h0014;
  localparam logic [15:0] SIG_CODE_VEL2   = 16'h0019;

  // ==========
  // Routing types and reset values.
  typedef enum logic [2:0] {SIG_FORCED, SIG_TQ1, SIG_VEL1, SIG_TQ2, SIG_VEL2} sig_sel_t;
  localparam sig_sel_t [3:0] ROUTE_RESET = {SIG_FORCED, SIG_FORCED, SIG_VEL2, SIG_VEL1};
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : ic_pkg

// >>> verilog/analog_route_mux.sv
/*
  Registered five-way analog output selector, one selector per connector.
  Assumes all analog sources are synchronous to clk_sys_in.
*/
`timescale 1ns/1ps
module analog_route_mux (
  // Clock and reset.
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  // Selection and sources.
  input  wire ic_pkg::sig_sel_t [3:0] route_in,
  input  wire logic [3:0][15:0]       forced_in,
  input  wire logic [15:0]            vel1_in,
  input  wire logic [15:0]            vel2_in,
  input  wire logic [15:0]            tq1_in,
  input  wire logic [15:0]            tq2_in,
  // Connector outputs.
  output logic [3:0][15:0]            ana_out
);

  typedef struct packed {
    logic [3:0][15:0] ana;
  } mux_state_t;

  mux_state_t       state_reg;
  mux_state_t       state_next;
  logic [3:0][15:0] pick;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_conn
      always_comb begin
        unique case (route_in[g])
          ic_pkg::SIG_TQ1:  pick[g] = tq1_in;
          ic_pkg::SIG_VEL1: pick[g] = vel1_in;
          ic_pkg::SIG_TQ2:  pick[g] = tq2_in;
          ic_pkg::SIG_VEL2: pick[g] = vel2_in;
          default:          pick[g] = forced_in[g];
        endcase
      end
    end
  endgenerate

  always_comb begin
    state_next     = state_reg;
    state_next.ana = pick;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ana_out = state_reg.ana;

endmodule : analog_route_mux

// >>> verilog/param_store.sv
/*
  Flip-flop store of double-word motion program parameters, one write port
  and one registered read port. Assumes writes come from the same clock.
*/
`timescale 1ns/1ps
module param_store #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock and reset.
  input  wire logic          clk_sys_in,
  input  wire logic          rst_n_in,
  // Write port.
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [31:0]   wr_data_in,
  // Read port.
  input  wire logic [AW-1:0] rd_addr_in,
  output logic [31:0]        rd_data_out
);

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0]            rdata;
  } store_state_t;

  store_state_t           state_reg;
  store_state_t           state_next;
  logic [DEPTH-1:0][31:0] mem_next;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      assign mem_next[g] = (wr_en_in && wr_addr_in == AW'(g)) ? wr_data_in
                                                              : state_reg.mem[g];
    end
  endgenerate

  always_comb begin
    state_next       = state_reg;
    state_next.mem   = mem_next;
    state_next.rdata = state_reg.mem[rd_addr_in];
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out = state_reg.rdata;

endmodule : param_store

// >>> verilog/imm_cmd_route.sv
/*
  Immediate command interpreter with analog output routing, configuration
  flag clearing, parameter loading and non-programmed motion exclusion.
  Assumes an APB master and motion logic on clk_sys_in.
*/
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module imm_cmd_route #(
  parameter int PARAM_DEPTH = 256
) (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Interrupt.
  output logic             irq_out,
  // Analog sources and connector outputs.
  input  wire logic [15:0] vel1_in,
  input  wire logic [15:0] vel2_in,
  input  wire logic [15:0] tq1_in,
  input  wire logic [15:0] tq2_in,
  output logic [3:0][15:0] ana_out,
  // Motion logic.
  input  wire logic [3:0]  motion_done_in,
  input  wire logic        reconfig_in,
  output logic [3:0]       motion_start_out,
  output logic [7:0]       motion_code_out,
  output logic [31:0]      motion_data_out,
  output logic [3:0]       home_start_out,
  output logic [3:0]       jog_out,
  output logic [3:0]       abort_out,
  output logic [3:0]       accel_prog_out,
  output logic             new_config_out
);

  // ==========
  // State.
  typedef struct packed {
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    logic [ic_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [ic_pkg::INT_WIDTH-1:0]  int_stat;
    logic [ic_pkg::INT_WIDTH-1:0]  int_mask;
    logic                        irq;
    logic [7:0]                  param_idx;
    logic [3:0][31:0]            cmd_hi;
    logic [3:0][15:0]            forced;
    ic_pkg::sig_sel_t [3:0]      route;
    logic                        new_cfg;
    logic [3:0]                  cmd_act;
    logic [3:0]                  home_act;
    logic [3:0]                  home_prev;
    logic [3:0]                  motion_start;
    logic [7:0]                  motion_code;
    logic [31:0]                 motion_data;
    logic [3:0]                  home_start;
    logic                        pwe;
    logic [7:0]                  pwaddr;
    logic [31:0]                 pwdata;
  } top_state_t;

  top_state_t  state_reg;
  top_state_t  state_next;
  logic [31:0] param_rdata;

  // ==========
  // Next state.
  always_comb begin : next_state
    logic [ic_pkg::INT_WIDTH-1:0] ev;
    logic [ic_pkg::INT_WIDTH-1:0] clr;
    logic [3:0]       act;
    logic [3:0]       dig;
    logic [3:0]       rise;
    logic [1:0]       slot;
    logic [1:0]       conn;
    logic [7:0]       code;
    logic [7:0]       arg;
    logic [31:0]      data;
    logic             conn_ok;
    logic             sig_ok;
    logic             addr_ok;
    logic             cfg_clr;
    ic_pkg::sig_sel_t sel;
    ev      = '0;
    clr     = '0;
    cfg_clr = 1'b0;
    sel     = ic_pkg::SIG_FORCED;
    sig_ok  = 1'b1;
    slot    = paddr_in[4:3];
    code    = pwdata_in[7:0];
    arg     = pwdata_in[15:8];
    data    = state_reg.cmd_hi[slot];
    conn    = 2'(arg - ic_pkg::CONN_FIRST);
    conn_ok = (arg >= ic_pkg::CONN_FIRST) && (arg <= ic_pkg::CONN_LAST);
    dig     = state_reg.ctrl[ic_pkg::CTRL_DIGITAL_LSB +: 4];
    state_next              = state_reg;
    state_next.motion_start = '0;
    state_next.home_start   = '0;
    state_next.pwe          = 1'b0;
    state_next.pready       = 1'b0;
    state_next.cmd_act      = state_reg.cmd_act & ~motion_done_in;
    state_next.home_act     = state_reg.home_act & ~motion_done_in;
    state_next.home_prev    = state_reg.ctrl[ic_pkg::CTRL_HOME_LSB +: 4];
    act = state_reg.ctrl[ic_pkg::CTRL_JOG_LSB +: 4] | state_reg.home_act | state_reg.cmd_act;

    addr_ok = (paddr_in[1:0] == 2'b00) &&
              ((paddr_in[7:5] == ic_pkg::CMD_REGION) ||
               (paddr_in <= ic_pkg::ADDR_PARAM_DATA));

    // Find home starts on the rising edge of its control bit.
    rise = state_reg.ctrl[ic_pkg::CTRL_HOME_LSB +: 4] & ~state_reg.home_prev;
    for (int i = 0; i < ic_pkg::NUM_AXES; i++) begin
      if (rise[i]) begin
        if (act[i]) begin
          ev[ic_pkg::INT_CONFLICT] = 1'b1;
        end else begin
          state_next.home_start[i] = 1'b1;
          state_next.home_act[i]   = 1'b1;
        end
      end
    end

    // Read data and error answer are prepared in the first access cycle.
    if (psel_in && penable_in && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !addr_ok;
      state_next.prdata  = '0;
      if (!pwrite_in) begin
        unique case (paddr_in)
          ic_pkg::ADDR_CTRL: begin
            state_next.prdata[ic_pkg::CTRL_WIDTH-1:0] = state_reg.ctrl;
          end
          ic_pkg::ADDR_STATUS: begin
            state_next.prdata[ic_pkg::STAT_NEWCFG_BIT]     = state_reg.new_cfg;
            state_next.prdata[ic_pkg::STAT_ACTIVE_LSB +: 4] = act;
            state_next.prdata[ic_pkg::STAT_ROUTE_LSB +: 12] = state_reg.route;
          end
          ic_pkg::ADDR_INT_STAT: begin
            state_next.prdata[ic_pkg::INT_WIDTH-1:0] = state_reg.int_stat;
          end
          ic_pkg::ADDR_INT_MASK: begin
            state_next.prdata[ic_pkg::INT_WIDTH-1:0] = state_reg.int_mask;
          end
          ic_pkg::ADDR_PARAM_IDX: begin
            state_next.prdata[7:0] = state_reg.param_idx;
          end
          ic_pkg::ADDR_PARAM_DATA: begin
            state_next.prdata = param_rdata;
          end
          default: begin
            if (addr_ok && paddr_in[2]) begin
              state_next.prdata = data;
            end
          end
        endcase
      end
    end

    // Writes take effect at the edge that completes the transfer.
    if (psel_in && penable_in && state_reg.pready && pwrite_in && addr_ok) begin
      unique case (paddr_in)
        ic_pkg::ADDR_CTRL:      state_next.ctrl      = pwdata_in[ic_pkg::CTRL_WIDTH-1:0];
        ic_pkg::ADDR_INT_STAT:  clr                  = pwdata_in[ic_pkg::INT_WIDTH-1:0];
        ic_pkg::ADDR_INT_MASK:  state_next.int_mask  = pwdata_in[ic_pkg::INT_WIDTH-1:0];
        ic_pkg::ADDR_PARAM_IDX: state_next.param_idx = pwdata_in[7:0];
        ic_pkg::ADDR_STATUS, ic_pkg::ADDR_PARAM_DATA: begin
        end
        default: begin
          if (paddr_in[2]) begin
            state_next.cmd_hi[slot] = pwdata_in;
          end else begin
            // A write of bytes 0-1 of any slot executes that slot's command.
            unique case (code)
              ic_pkg::CODE_ROUTE: begin
                unique case (data[15:0])
                  ic_pkg::SIG_CODE_FORCED: sel = ic_pkg::SIG_FORCED;
                  ic_pkg::SIG_CODE_TQ1:    sel = ic_pkg::SIG_TQ1;
                  ic_pkg::SIG_CODE_VEL1:   sel = ic_pkg::SIG_VEL1;
                  ic_pkg::SIG_CODE_TQ2:    sel = ic_pkg::SIG_TQ2;
                  ic_pkg::SIG_CODE_VEL2:   sel = ic_pkg::SIG_VEL2;
                  default:                 sig_ok = 1'b0;
                endcase
                // Forced data may only return to its own connector C or D.
                if (sel == ic_pkg::SIG_FORCED && ic_pkg::ROUTE_RESET[conn] != sel) begin
                  sig_ok = 1'b0;
                end
                if (!conn_ok || !sig_ok) begin
                  ev[ic_pkg::INT_BADCMD] = 1'b1;
                end else begin
                  if (!dig[conn]) begin
                    state_next.route[conn] = sel;
                  end
                  ev[ic_pkg::INT_DONE] = 1'b1;
                end
              end
              ic_pkg::CODE_CLR_CFG: begin
                cfg_clr              = 1'b1;
                ev[ic_pkg::INT_DONE] = 1'b1;
              end
              ic_pkg::CODE_LOAD_PARAM: begin
                state_next.pwe        = 1'b1;
                state_next.pwaddr     = arg;
                state_next.pwdata     = data;
                ev[ic_pkg::INT_PARAM] = 1'b1;
                ev[ic_pkg::INT_DONE]  = 1'b1;
              end
              ic_pkg::CODE_VEL_MOVE, ic_pkg::CODE_MOVE, ic_pkg::CODE_FORCE_VEL,
              ic_pkg::CODE_FORCE_ANA, ic_pkg::CODE_POS_INC: begin
                if (act[slot] && code != ic_pkg::CODE_POS_INC) begin
                  ev[ic_pkg::INT_CONFLICT] = 1'b1;
                end else begin
                  state_next.motion_start[slot] = 1'b1;
                  state_next.motion_code        = code;
                  state_next.motion_data        = data;
                  ev[ic_pkg::INT_DONE]          = 1'b1;
                  if (code == ic_pkg::CODE_VEL_MOVE || code == ic_pkg::CODE_MOVE ||
                      code == ic_pkg::CODE_FORCE_VEL) begin
                    state_next.cmd_act[slot] = 1'b1;
                  end
                  if (code == ic_pkg::CODE_FORCE_ANA && !dig[slot]) begin
                    state_next.forced[slot] = data[15:0];
                  end
                end
              end
              default: ev[ic_pkg::INT_BADCMD] = 1'b1;
            endcase
          end
        end
      endcase
    end

    // Hardware set wins over software clear.
    state_next.new_cfg  = (state_reg.new_cfg & ~cfg_clr) | reconfig_in;
    state_next.int_stat = (state_reg.int_stat & ~clr) | ev;
    state_next.irq      = |(state_next.int_stat & state_next.int_mask);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg         <= '0;
      state_reg.route   <= ic_pkg::ROUTE_RESET;
      state_reg.new_cfg <= 1'b1;
      state_reg.prdata  <= ic_pkg::RDATA_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========
  // Submodules.
  analog_route_mux u_mux (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .route_in   (state_reg.route),
    .forced_in  (state_reg.forced),
    .vel1_in    (vel1_in),
    .vel2_in    (vel2_in),
    .tq1_in     (tq1_in),
    .tq2_in     (tq2_in),
    .ana_out    (ana_out)
  );

  param_store #(
    .DEPTH (PARAM_DEPTH),
    .AW    (8)
  ) u_params (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (state_reg.pwe),
    .wr_addr_in  (state_reg.pwaddr),
    .wr_data_in  (state_reg.pwdata),
    .rd_addr_in  (state_reg.param_idx),
    .rd_data_out (param_rdata)
  );

  // ==========
  // Outputs.
  assign prdata_out       = state_reg.prdata;
  assign pready_out       = state_reg.pready;
  assign pslverr_out      = state_reg.pslverr;
  assign irq_out          = state_reg.irq;
  assign motion_start_out = state_reg.motion_start;
  assign motion_code_out  = state_reg.motion_code;
  assign motion_data_out  = state_reg.motion_data;
  assign home_start_out   = state_reg.home_start;
  assign jog_out          = state_reg.ctrl[ic_pkg::CTRL_JOG_LSB +: 4];
  assign abort_out        = state_reg.ctrl[ic_pkg::CTRL_ABORT_LSB +: 4];
  // Feed hold uses programmed acceleration; all else stays on jog acceleration.
  assign accel_prog_out   = state_reg.ctrl[ic_pkg::CTRL_HOLD_LSB +: 4];
  assign new_config_out   = state_reg.new_cfg;

endmodule : imm_cmd_route

// >>> verif/host_apb.sv
/* APB host model that writes immediate command words into a slot.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
module host_apb (
  // Clock.
  input  wire logic        clk_in,
  // Request.
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out,
  // Answer.
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in
);
  logic [31:0] q;
  logic        e;
  initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
  // ==========
  // Transfers.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    @(posedge clk_in);
  endtask : xfer
  // Bytes 4-7 go first; writing bytes 0-1 makes the command run.
  task automatic cmd(input int s, input logic [7:0] cd, ag, input logic [31:0] hi);
    xfer(1'b1, 8'(8'h24 + 8 * s), hi);
    xfer(1'b1, 8'(8'h20 + 8 * s), {16'h0000, ag, cd});
  endtask : cmd
endmodule : host_apb

// >>> verif/imm_cmd_route_chk.sv
/* Port checks of the command interpreter.
   Assumes one APB wait state and flopped outputs. */
`timescale 1ns/1ps
module imm_cmd_route_chk #(
  parameter int PARAM_DEPTH = 256
) (
  // Clock and reset.
  input wire logic             clk_sys_in,
  input wire logic             rst_n_in,
  // APB.
  input wire logic             psel_in,
  input wire logic             penable_in,
  input wire logic             pwrite_in,
  input wire logic [7:0]       paddr_in,
  input wire logic [31:0]      pwdata_in,
  input wire logic             pready_out,
  input wire logic             pslverr_out,
  // Analog and motion.
  input wire logic [15:0]      vel1_in,
  input wire logic [15:0]      vel2_in,
  input wire logic             reconfig_in,
  input wire logic [3:0][15:0] ana_out,
  input wire logic [3:0]       motion_start_out,
  input wire logic [7:0]       motion_code_out,
  input wire logic [3:0]       home_start_out,
  input wire logic [3:0]       jog_out,
  input wire logic [3:0]       accel_prog_out,
  input wire logic             new_config_out
);
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ==========
  // Transfer phases.
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_wait; psel_in && penable_in && !pready_out; endsequence
  sequence s_done; psel_in && penable_in && pready_out && pwrite_in; endsequence
  chk_ready_wait: assert property (s_setup ##1 s_wait |=> pready_out)
    else $error("pready not after one wait state");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  chk_err_align: assert property (pready_out && paddr_in[1:0] != 2'b00 |-> pslverr_out)
    else $error("unaligned access not refused");
  chk_ctrl_mirror: assert property (s_done ##0 paddr_in == ic_pkg::ADDR_CTRL
    |=> accel_prog_out == $past(pwdata_in[11:8]) && jog_out == $past(pwdata_in[3:0]))
    else $error("control levels wrong");
  chk_pos_inc: assert property (s_done ##0 paddr_in[7:5] == ic_pkg::CMD_REGION
    && paddr_in[2:0] == 3'h0 && pwdata_in[7:0] == ic_pkg::CODE_POS_INC
    |=> motion_start_out == 4'(1 << $past(paddr_in[4:3]))
    && motion_code_out == ic_pkg::CODE_POS_INC)
    else $error("position increment refused");
  chk_start_pulse: assert property (motion_start_out != 4'h0 |=> motion_start_out == 4'h0)
    else $error("motion start not a pulse");
  chk_home_pulse: assert property (home_start_out != 4'h0 |=> home_start_out == 4'h0)
    else $error("home start not a pulse");
  chk_cfg_set: assert property (reconfig_in |=> new_config_out)
    else $error("new configuration flag not set");
  chk_rst_route: assert property ($rose(rst_n_in) |=> ana_out[0] == $past(vel1_in)
    && ana_out[1] == $past(vel2_in) && ana_out[2] == 16'h0000 && ana_out[3] == 16'h0000)
    else $error("default routing missing after reset");
endmodule : imm_cmd_route_chk
bind imm_cmd_route imm_cmd_route_chk #(.PARAM_DEPTH(PARAM_DEPTH)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .vel1_in(vel1_in), .vel2_in(vel2_in), .reconfig_in(reconfig_in),
  .ana_out(ana_out), .motion_start_out(motion_start_out), .motion_code_out(motion_code_out),
  .home_start_out(home_start_out), .jog_out(jog_out), .accel_prog_out(accel_prog_out),
  .new_config_out(new_config_out));

// >>> verif/tb.sv
/* Self-checking bench of the command interpreter against an integer model.
   Assumes the host model drives APB and the bench drives motion inputs. */
`timescale 1ns/1ps
module tb;
  // ==========
  // Signals and model state.
  logic             clk_sys_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic             irq_out, reconfig, new_cfg;
  logic [7:0]       paddr, motion_code;
  logic [31:0]      pwdata, prdata, motion_data, v;
  logic [15:0]      vel1, vel2, tq1, tq2, f, frc[4];
  logic [3:0][15:0] ana_out;
  logic [3:0]       motion_done, motion_start, home_start, jog_out, abort_out, accel_prog_out;
  logic [3:0]       st_seen, hm_seen;
  int               rt[4], act, ncfg, dig, i, s, c, g, m, k, bad, cyc, err_total, tests_run, seed;
  int               sig_tbl[6] = '{0, 10, 15, 20, 25, 11};
  logic [7:0]       mv[3] = '{ic_pkg::CODE_VEL_MOVE, ic_pkg::CODE_MOVE, ic_pkg::CODE_FORCE_VEL};
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    st_seen |= motion_start;
    hm_seen |= home_start;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  host_apb host (.clk_in(clk_sys_in), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));
  imm_cmd_route #(.PARAM_DEPTH(256)) DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq_out), .vel1_in(vel1), .vel2_in(vel2), .tq1_in(tq1), .tq2_in(tq2),
    .ana_out(ana_out), .motion_done_in(motion_done), .reconfig_in(reconfig),
    .motion_start_out(motion_start), .motion_code_out(motion_code),
    .motion_data_out(motion_data), .home_start_out(home_start), .jog_out(jog_out),
    .abort_out(abort_out), .accel_prog_out(accel_prog_out), .new_config_out(new_cfg));
  // ==========
  // Model and helpers.
  function automatic int sig_idx(input int code);
    for (int n = 0; n < 5; n++) if (sig_tbl[n] == code) return n;
    return -1;
  endfunction : sig_idx
  function automatic logic [15:0] src(input int n);
    case (rt[n])
      0: return frc[n];
      1: return tq1;
      2: return vel1;
      3: return tq2;
      default: return vel2;
    endcase
  endfunction : src
  task automatic stc();
    rdc(ic_pkg::ADDR_STATUS,
        {4'h0, 3'(rt[3]), 3'(rt[2]), 3'(rt[1]), 3'(rt[0]), 8'h00, 4'(act), 3'h0, 1'(ncfg)});
    for (int n = 0; n < 4; n++) chk(ana_out[n], src(n));
  endtask : stc
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000);
    chk(host.q, exp);
  endtask : rdc
  task automatic op(input int sl, input logic [7:0] cd, input logic [31:0] d, input int st, hm, cf);
    st_seen = 4'h0;
    hm_seen = 4'h0;
    if (cd == 8'h00) host.xfer(1'b1, ic_pkg::ADDR_CTRL, d);
    else host.cmd(sl, cd, 8'h00, d);
    repeat (2) @(posedge clk_sys_in);
    chk(st_seen, st << sl);
    if (st) chk(motion_code, cd);
    if (st) chk(motion_data, d);
    chk(hm_seen, hm << sl);
    host.xfer(1'b0, ic_pkg::ADDR_INT_STAT, 32'h0000_0000);
    chk(host.q[1], cf);
    host.xfer(1'b1, ic_pkg::ADDR_INT_STAT, 32'h0000_000f);
    if ((st && cd != ic_pkg::CODE_POS_INC) || hm) act |= 1 << sl;
    stc();
  endtask : op
  task automatic settle(input int sl);
    motion_done <= 4'(1 << sl);
    @(posedge clk_sys_in);
    motion_done <= 4'h0;
    act = 0;
    stc();
  endtask : settle
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // ==========
  // Main sequence.
  initial begin
    seed = 25621;
    {clk_sys_in, rst_n_in, reconfig, motion_done} = '0;
    {vel1, vel2, tq1, tq2} = {$random(seed), $random(seed)};
    rt = '{2, 4, 0, 0};
    frc = '{default: 16'h0000};
    ncfg = 1;
    act = 0;
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    stc();
    for (i = 0; i < 40; i++) begin
      s = {$random(seed)} % 4;
      c = {$random(seed)} % 6;
      g = sig_tbl[{$random(seed)} % 6];
      m = {$random(seed)} % 2;
      if (i % 8 == 0) begin
        dig = {$random(seed)} % 16;
        host.xfer(1'b1, ic_pkg::ADDR_CTRL, 32'(dig) << 16);
      end
      host.xfer(1'b1, ic_pkg::ADDR_INT_MASK, m ? 32'h0000_0004 : 32'h0000_0000);
      {vel1, vel2, tq1, tq2} <= {$random(seed), $random(seed)};
      if (i % 5 == 4) begin
        f = 16'($random(seed));
        host.cmd(s, ic_pkg::CODE_FORCE_ANA, 8'h00, {16'h0000, f});
        bad = 0;
        if (!dig[s]) frc[s] = f;
      end else begin
        host.cmd(s, ic_pkg::CODE_ROUTE, 8'(c), 32'(g));
        bad = c < 1 || c > 4 || sig_idx(g) < 0 || (g == 0 && c < 3);
        if (!bad && !dig[c - 1]) rt[c - 1] = sig_idx(g);
      end
      host.xfer(1'b0, ic_pkg::ADDR_INT_STAT, 32'h0000_0000);
      chk(host.q[2], bad);
      chk(irq_out, bad && m);
      host.xfer(1'b1, ic_pkg::ADDR_INT_STAT, 32'h0000_000f);
      stc();
    end
    host.cmd(3, ic_pkg::CODE_CLR_CFG, 8'h00, 32'h0000_0000);
    ncfg = 0;
    chk(new_cfg, 0);
    reconfig <= 1'b1;
    @(posedge clk_sys_in);
    reconfig <= 1'b0;
    ncfg = 1;
    stc();
    for (i = 0; i < 6; i++) begin
      k = (i == 0) ? 0 : (i == 1) ? 255 : {$random(seed)} % 256;
      v = $random(seed);
      host.cmd(i % 4, ic_pkg::CODE_LOAD_PARAM, 8'(k), v);
      host.xfer(1'b1, ic_pkg::ADDR_PARAM_IDX, 32'(k));
      rdc(ic_pkg::ADDR_PARAM_DATA, v);
    end
    host.xfer(1'b1, ic_pkg::ADDR_CTRL, 32'h0000_0000);
    for (i = 0; i < 3; i++) begin
      op(1, mv[i], $random(seed), 1, 0, 0);
      op(1, mv[(i + 1) % 3], $random(seed), 0, 0, 1);
      op(1, ic_pkg::CODE_POS_INC, $random(seed), 1, 0, 0);
      if (i == 0) op(1, 8'h00, 32'h0000_0020, 0, 0, 1);
      op(1, 8'h00, 32'h0000_0000, 0, 0, 0);
      settle(1);
    end
    op(1, 8'h00, 32'h0000_0020, 0, 1, 0);
    settle(1);
    act = 2;
    op(1, 8'h00, 32'h0000_af02, 0, 0, 0);
    chk(accel_prog_out, 4'hf);
    chk(abort_out, 4'ha);
    op(1, ic_pkg::CODE_MOVE, $random(seed), 0, 0, 1);
    act = 0;
    op(1, 8'h00, 32'h0000_0000, 0, 0, 0);
    chk(accel_prog_out, 4'h0);
    host.xfer(1'b0, 8'h80, 32'h0000_0000);
    chk(host.e, 1);
    chk(host.q, 0);
    host.xfer(1'b0, 8'h02, 32'h0000_0000);
    chk(host.e, 1);
    test_done();
  end
endmodule : tb
